// ==== verilog/rshp_ctrl.v ====
// Contract
// - In manual switching mode the reference pin is an input choosing the reference.
// - In automatic switching mode the device drives the reference pin with the reference in use.
// - Low on the reference pin means input A and high means input B.
// - In manual hold mode a high hold pin forces the hold state.
// - In automatic hold mode the device drives the hold pin high while holding.
// - While the sleep pin is high the device is inactive and fully powered down.
// - While the reset pin is high all chip logic is held in reset; the code resets state_r and active_ref but not core_sleep.
`timescale 1ns/1ps
`include "rshp_consts.vh"
module rshp_ctrl (
    core_clk,
    rst_b,
    chip_reset_pin,
    sleep_pin,
    ref_auto_mode,
    hold_auto_mode,
    ref_a_lost,
    ref_b_lost,
    ref_choice_pin_in,
    ref_choice_pin_out,
    ref_choice_pin_oe,
    hold_pin_in,
    hold_pin_out,
    hold_pin_oe,
    active_ref,
    hold_active,
    core_sleep,
    core_reset
);
    input wire core_clk;
    input wire rst_b;
    input wire chip_reset_pin;
    input wire sleep_pin;
    input wire ref_auto_mode;
    input wire hold_auto_mode;
    input wire ref_a_lost;
    input wire ref_b_lost;
    input wire ref_choice_pin_in;
    output wire ref_choice_pin_out;
    output wire ref_choice_pin_oe;
    input wire hold_pin_in;
    output wire hold_pin_out;
    output wire hold_pin_oe;
    output reg active_ref;
    output wire hold_active;
    output reg core_sleep;
    output reg core_reset;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg active_ref_nxt;
    reg hold_req;
    wire ref_level;
    wire hold_level;
    wire both_lost;
    wire blank;
    wire switch_to_b;
    wire switch_to_a;

    assign both_lost = ref_a_lost && ref_b_lost;
    assign blank = core_reset || core_sleep;
    assign hold_active = (state_r == `RSHP_ST_HOLD);

    // Switch only while the other reference is still good
    assign switch_to_b = (active_ref == `RSHP_REF_A) && ref_a_lost
        && !ref_b_lost;
    assign switch_to_a = (active_ref == `RSHP_REF_B) && ref_b_lost
        && !ref_a_lost;

    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            core_reset <= `RSHP_RST_CORE_RESET;
        end
        else
        begin
            core_reset <= chip_reset_pin;
        end
    end

    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            core_sleep <= `RSHP_RST_CORE_SLEEP;
        end
        else
        begin
            core_sleep <= sleep_pin;
        end
    end

    rshp_pin_dir u_ref_pin (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .mode_auto(ref_auto_mode),
        .blank(blank),
        .pin_in(ref_choice_pin_in),
        .status_val(active_ref),
        .pin_out(ref_choice_pin_out),
        .pin_oe(ref_choice_pin_oe),
        .pin_level(ref_level)
    );

    rshp_pin_dir u_hold_pin (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .mode_auto(hold_auto_mode),
        .blank(blank),
        .pin_in(hold_pin_in),
        .status_val(hold_active),
        .pin_out(hold_pin_out),
        .pin_oe(hold_pin_oe),
        .pin_level(hold_level)
    );

    always @*
    begin
        active_ref_nxt = active_ref;
        if (ref_auto_mode == `RSHP_MODE_MANUAL)
        begin
            // low is A, high is B
            active_ref_nxt = ref_level;
        end
        else if (switch_to_b)
        begin
            active_ref_nxt = `RSHP_REF_B;
        end
        else if (switch_to_a)
        begin
            active_ref_nxt = `RSHP_REF_A;
        end
    end

    // Hold request as seen in the current hold mode
    always @*
    begin
        hold_req = both_lost;
        if (hold_auto_mode == `RSHP_MODE_MANUAL)
        begin
            hold_req = hold_level;
        end
    end

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            `RSHP_ST_RUN:
            begin
                if (hold_req)
                begin
                    state_nxt = `RSHP_ST_HOLD;
                end
            end
            `RSHP_ST_HOLD:
            begin
                if (!hold_req)
                begin
                    state_nxt = `RSHP_ST_RUN;
                end
            end
            `RSHP_ST_SLEEP:
            begin
                // Leave power-down straight into a pending hold
                if (hold_req)
                begin
                    state_nxt = `RSHP_ST_HOLD;
                end
                else
                begin
                    state_nxt = `RSHP_ST_RUN;
                end
            end
            default:
            begin
                state_nxt = `RSHP_ST_RUN;
            end
        endcase
        if (core_sleep)
        begin
            state_nxt = `RSHP_ST_SLEEP;
        end
    end

    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= `RSHP_ST_RUN;
        end
        else if (core_reset)
        begin
            state_r <= `RSHP_ST_RUN;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            active_ref <= `RSHP_RST_REF;
        end
        else if (core_reset)
        begin
            active_ref <= `RSHP_RST_REF;
        end
        else if (!core_sleep)
        begin
            active_ref <= active_ref_nxt;
        end
    end
endmodule

// ==== verilog/rshp_consts.vh ====
`ifndef RSHP_CONSTS_VH
`define RSHP_CONSTS_VH
// Pin level meaning
`define RSHP_REF_A 1'h0
`define RSHP_REF_B 1'h1
// Mode encodings
`define RSHP_MODE_MANUAL 1'h0
`define RSHP_MODE_AUTO 1'h1
// Reset values
`define RSHP_RST_REF 1'h0
`define RSHP_RST_HOLD 1'h0
`define RSHP_RST_CORE_RESET 1'h1
`define RSHP_RST_CORE_SLEEP 1'h0
`define RSHP_RST_PIN_OUT 1'h0
`define RSHP_RST_PIN_OE 1'h0
// One-hot states of the holdover tracker
`define RSHP_ST_RUN 3'h1
`define RSHP_ST_HOLD 3'h2
`define RSHP_ST_SLEEP 3'h4
`endif

// ==== verilog/rshp_pin_dir.v ====
`timescale 1ns/1ps
`include "rshp_consts.vh"
// One configurable two-way control pin
module rshp_pin_dir (
    core_clk,
    rst_b,
    mode_auto,
    blank,
    pin_in,
    status_val,
    pin_out,
    pin_oe,
    pin_level
);
    input wire core_clk;
    input wire rst_b;
    input wire mode_auto;
    input wire blank;
    input wire pin_in;
    input wire status_val;
    output reg pin_out;
    output reg pin_oe;
    output wire pin_level;

    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_out <= `RSHP_RST_PIN_OUT;
            pin_oe <= `RSHP_RST_PIN_OE;
        end
        else
        begin
            pin_out <= status_val;
            pin_oe <= (mode_auto == `RSHP_MODE_AUTO) && !blank;
        end
    end

    // Level the core acts on: pin in manual, own status in auto
    assign pin_level = (mode_auto == `RSHP_MODE_AUTO) ? status_val : pin_in;
endmodule

// ==== dv/rshp_pins_host.sv ====
`timescale 1ns/1ps
// Board logic sharing the two control pins
module rshp_pins_host (
    input wire want_ref,
    input wire want_hold,
    input wire ref_out,
    input wire ref_oe,
    input wire hold_out,
    input wire hold_oe,
    output wire ref_wire,
    output wire hold_wire
);
    assign ref_wire = ref_oe ? ref_out : want_ref;
    assign hold_wire = hold_oe ? hold_out : want_hold;
endmodule

// ==== dv/rshp_ctrl_sva.sv ====
`timescale 1ns/1ps
module rshp_ctrl_sva (
    input wire core_clk,
    input wire rst_b,
    input wire ref_auto_mode,
    input wire hold_auto_mode,
    input wire ref_a_lost,
    input wire ref_b_lost,
    input wire ref_choice_pin_in,
    input wire hold_pin_in,
    input wire active_ref,
    input wire ref_choice_pin_out,
    input wire ref_choice_pin_oe,
    input wire hold_pin_out,
    input wire hold_pin_oe,
    input wire hold_active,
    input wire core_sleep,
    input wire core_reset
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_man_steady;
        (!ref_auto_mode && !core_reset && !core_sleep
        && $stable(ref_choice_pin_in))[*3];
    endsequence
    sequence s_hold_forced;
        (!hold_auto_mode && hold_pin_in && !core_reset && !core_sleep)[*2];
    endsequence
    sequence s_both_lost;
        (hold_auto_mode && ref_a_lost && ref_b_lost && !core_reset
        && !core_sleep)[*2];
    endsequence

    property p_man;
        s_man_steady |-> active_ref == ref_choice_pin_in;
    endproperty
    a_man: assert property (p_man) else $error("ref");
    property p_rout;
        ref_choice_pin_oe |-> ref_choice_pin_out == $past(active_ref);
    endproperty
    a_rout: assert property (p_rout) else $error("rout");
    property p_roe;
        ref_choice_pin_oe |-> $past(ref_auto_mode);
    endproperty
    a_roe: assert property (p_roe) else $error("roe");
    property p_hold;
        s_hold_forced |-> hold_active;
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_hout;
        hold_pin_oe |-> hold_pin_out == $past(hold_active);
    endproperty
    a_hout: assert property (p_hout) else $error("hout");
    property p_ahold;
        s_both_lost |-> hold_active;
    endproperty
    a_ahold: assert property (p_ahold) else $error("auto hold");
    property p_slp;
        core_sleep |=> !ref_choice_pin_oe && !hold_pin_oe && !hold_active;
    endproperty
    a_slp: assert property (p_slp) else $error("sleep");
    property p_rst;
        core_reset |=> !active_ref && !ref_choice_pin_oe && !hold_pin_oe;
    endproperty
    a_rst: assert property (p_rst) else $error("reset");
endmodule
bind rshp_ctrl rshp_ctrl_sva rshp_ctrl_sva_inst (.core_clk, .rst_b,
    .ref_auto_mode, .hold_auto_mode, .ref_a_lost, .ref_b_lost,
    .ref_choice_pin_in, .hold_pin_in,
    .active_ref, .ref_choice_pin_out, .ref_choice_pin_oe, .hold_pin_out,
    .hold_pin_oe, .hold_active, .core_sleep, .core_reset);

// ==== dv/rshp_ctrl_bench.sv ====
`timescale 1ns/1ps
module rshp_ctrl_bench;
reg core_clk = 0, rst_b = 0, rp = 0, sp = 0, ram = 0, ham = 0;
reg al = 0, bl = 0, wr = 0, wh = 0;
wire rw, hw, ro, roe, ho, hoe, ar, ha, cs, cr;
integer failures = 0, checked = 0;
always #5 core_clk = ~core_clk;
rshp_ctrl rshp_ctrl_inst (.core_clk, .rst_b, .chip_reset_pin(rp),
    .sleep_pin(sp), .ref_auto_mode(ram), .hold_auto_mode(ham),
    .ref_a_lost(al), .ref_b_lost(bl), .ref_choice_pin_in(rw),
    .ref_choice_pin_out(ro), .ref_choice_pin_oe(roe), .hold_pin_in(hw),
    .hold_pin_out(ho), .hold_pin_oe(hoe), .active_ref(ar),
    .hold_active(ha), .core_sleep(cs), .core_reset(cr));
rshp_pins_host rshp_pins_host_inst (.want_ref(wr), .want_hold(wh),
    .ref_out(ro), .ref_oe(roe), .hold_out(ho), .hold_oe(hoe),
    .ref_wire(rw), .hold_wire(hw));
task cyc(input integer n);
    repeat (n) @(posedge core_clk);
    #1;
endtask
task chk(input [63:0] nm, input v, input e);
    checked = checked + 1;
    if (v !== e)
    begin
        failures = failures + 1;
        $display("ERROR %0s exp %b seen %b", nm, e, v);
    end
endtask
task test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
task t_reset;
    @(posedge core_clk);
    wr <= 1;
    rp <= 1;
    cyc(4);
    chk("rst", cr, 1);
    chk("ref", ar, 0);
    @(posedge core_clk);
    rp <= 0;
    cyc(4);
    chk("rst", cr, 0);
    chk("ref", ar, 1);
    @(posedge core_clk);
    wr <= 0;
    cyc(4);
    chk("ref", ar, 0);
    chk("roe", roe, 0);
endtask
task t_auto;
    @(posedge core_clk);
    ram <= 1;
    al <= 1;
    cyc(4);
    chk("ref", ar, 1);
    chk("rpin", rw, 1);
    chk("roe", roe, 1);
    @(posedge core_clk);
    al <= 0;
    bl <= 1;
    cyc(4);
    chk("rpin", rw, 0);
    @(posedge core_clk);
    bl <= 0;
endtask
task t_hold;
    @(posedge core_clk);
    wh <= 1;
    cyc(3);
    chk("hold", ha, 1);
    chk("hoe", hoe, 0);
    @(posedge core_clk);
    wh <= 0;
    cyc(3);
    chk("hold", ha, 0);
    @(posedge core_clk);
    ham <= 1;
    al <= 1;
    bl <= 1;
    cyc(4);
    chk("hpin", hw, 1);
    chk("hoe", hoe, 1);
    @(posedge core_clk);
    al <= 0;
    bl <= 0;
    cyc(4);
    chk("hpin", hw, 0);
endtask
task t_sleep;
    @(posedge core_clk);
    sp <= 1;
    cyc(3);
    chk("slp", cs, 1);
    chk("hoe", hoe, 0);
    chk("roe", roe, 0);
    @(posedge core_clk);
    sp <= 0;
    al <= 1;
    bl <= 1;
    cyc(4);
    chk("hoe", hoe, 1);
    chk("hold", ha, 1);
endtask
initial
begin
    repeat (20) @(posedge core_clk);
    rst_b <= 1;
    t_reset;
    t_auto;
    t_hold;
    t_sleep;
    test_done;
end
endmodule
